//--- core/ahmp_defs.svh
// timing and width constants for the host microport
// assumes inclusion by both port ends and the interface
`ifndef AHMP_DEFS_SVH
`define AHMP_DEFS_SVH

`define AHMP_ADDR_W      14
`define AHMP_DATA_W      16
`define AHMP_CLK_NS      50
// internal access latency of the device, in clock cycles
`define AHMP_ACC_CYC     2
// host wait limit before giving up on the acknowledge, cycles
`define AHMP_TMO_CYC     64
`define AHMP_CNT_W       7

`endif

//--- core/ahmp_dev.sv
// device end of the asynchronous host microport
// assumes port pins come from another domain; user side is on ref_clk_in
//
// Behaviour
// - low port select selects the port
// - access starts on strobe and select low
// - direction input picks read or write
// - 14-bit address selects memories and registers
// - 16-bit bus, device drives only on reads
// - device pulls acknowledge low when done
`timescale 1ns/10ps
`default_nettype none
`include "ahmp_defs.svh"

module ahmp_dev
  import ahmp_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  ahmp_if.device          port,
  output logic            acc_req_out,   // one-cycle access pulse
  output logic            acc_wr_out,
  output ahmp_addr_t      acc_addr_out,
  output ahmp_data_t      acc_wdata_out,
  input  wire ahmp_data_t acc_rdata_in   // valid while acc_req_out
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] sync_sel;
  logic [1:0] sync_stb;
  logic       active;
  ahmp_dev_st_t state;
  ahmp_dev_st_t next_state;
  logic [`AHMP_CNT_W-1:0] cnt;
  logic [`AHMP_CNT_W-1:0] next_cnt;
  ahmp_data_t rdata;
  ahmp_data_t next_rdata;
  logic       is_rd;
  logic       next_is_rd;
  logic       next_acc_req;
  logic       next_acc_wr;
  ahmp_addr_t next_acc_addr;
  ahmp_data_t next_acc_wdata;

  // two flops on select and strobe
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sync_sel <= 2'h3;
      sync_stb <= 2'h3;
    end else begin
      sync_sel <= {sync_sel[0], port.sel_n};
      sync_stb <= {sync_stb[0], port.strobe_n};
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers for direction, address and write data
  // ---------------------------------------------------------------
  // the host sets these before it lowers the strobe and holds them
  // until it has seen the acknowledge; two flops keep a metastable
  // level away from the decode; the strobe path is just as deep and
  // the access starts a cycle later still, so the copy has settled
  // limitation: a host that moves them under the strobe gets a mix
  logic       sync_dir_0;
  logic       sync_dir;
  ahmp_addr_t sync_addr_0;
  ahmp_addr_t sync_addr;
  ahmp_data_t sync_data_0;
  ahmp_data_t sync_data;

  // two flops on direction, address and data lines
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sync_dir_0  <= 1'b0;
      sync_dir    <= 1'b0;
      sync_addr_0 <= '0;
      sync_addr   <= '0;
      sync_data_0 <= '0;
      sync_data   <= '0;
    end else begin
      sync_dir_0  <= port.rd_wr;
      sync_dir    <= sync_dir_0;
      sync_addr_0 <= port.host_addr;
      sync_addr   <= sync_addr_0;
      sync_data_0 <= port.host_data;
      sync_data   <= sync_data_0;
    end
  end

  // joint low level of select and strobe
  assign active = !sync_sel[1] && !sync_stb[1];

  // cycle walk, counted from the edge at which the strobe falls:
  //   +1, +2  strobe and select pass the two synchroniser flops
  //   +3      access pulse to the user side, read data captured at +4
  //   +5      acknowledge driven low, read data on the bus
  // the acknowledge then stands until the strobe or the select is
  // seen high again, two edges after the host lets go of it
  // hazard: a strobe that ends before the acknowledge still leaves
  // the access pulse issued; the user side cannot take it back, so
  // a write may land although the host saw no acknowledge

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  // next state; address, data and direction stable under strobe
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_rdata     = rdata;
    next_is_rd     = is_rd;
    next_acc_req   = 1'b0;
    next_acc_wr    = acc_wr_out;
    next_acc_addr  = acc_addr_out;
    next_acc_wdata = acc_wdata_out;
    unique case (state)
      AHMP_DEV_IDLE: begin
        if (active) begin
          next_acc_req   = 1'b1;
          next_acc_wr    = !sync_dir;
          next_is_rd     = sync_dir;
          next_acc_addr  = sync_addr;
          next_acc_wdata = sync_data;
          next_cnt       = `AHMP_CNT_W'(`AHMP_ACC_CYC);
          next_state     = AHMP_DEV_WAIT;
        end
      end
      AHMP_DEV_WAIT: begin
        if (acc_req_out) begin
          next_rdata = acc_rdata_in;
        end
        if (!active) begin
          next_state = AHMP_DEV_IDLE;
        end else if (cnt <= `AHMP_CNT_W'(1)) begin
          next_state = AHMP_DEV_ACK;
        end else begin
          next_cnt = cnt - `AHMP_CNT_W'(1);
        end
      end
      AHMP_DEV_ACK: begin
        if (!active) begin
          next_state = AHMP_DEV_IDLE;
        end
      end
      default: begin
        next_state = AHMP_DEV_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state         <= AHMP_DEV_IDLE;
      cnt           <= '0;
      rdata         <= '0;
      is_rd         <= 1'b0;
      acc_req_out   <= 1'b0;
      acc_wr_out    <= 1'b0;
      acc_addr_out  <= '0;
      acc_wdata_out <= '0;
    end else begin
      state         <= next_state;
      cnt           <= next_cnt;
      rdata         <= next_rdata;
      is_rd         <= next_is_rd;
      acc_req_out   <= next_acc_req;
      acc_wr_out    <= next_acc_wr;
      acc_addr_out  <= next_acc_addr;
      acc_wdata_out <= next_acc_wdata;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // ack and read data only in the ack state; the ack line is only
  // ever pulled low, the pull-up on the board returns it high, and
  // the bus is released in the same cycle as the ack, so the host
  // never sees read data without the ack standing beside it
  assign port.xfer_ack_n_d   = 1'b0;
  assign port.xfer_ack_oe_d  = (state == AHMP_DEV_ACK);
  assign port.host_data_d    = rdata;
  assign port.host_data_oe_d = (state == AHMP_DEV_ACK) && is_rd;

endmodule : ahmp_dev
`default_nettype wire

//--- core/ahmp_host.sv
// host end of the asynchronous host microport
// assumes the device answers with an acknowledge; user side on ref_clk_in
`timescale 1ns/10ps
`default_nettype none
`include "ahmp_defs.svh"

module ahmp_host
  import ahmp_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  ahmp_if.host            port,
  input  wire logic       cmd_valid_in,
  output logic            cmd_ready_out,
  input  wire logic       cmd_wr_in,
  input  wire ahmp_addr_t cmd_addr_in,
  input  wire ahmp_data_t cmd_wdata_in,
  output logic            rsp_valid_out,  // one-cycle pulse
  output logic            rsp_timeout_out,
  output ahmp_data_t      rsp_rdata_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ahmp_hst_st_t state;
  ahmp_hst_st_t next_state;
  logic [1:0]   sync_ack;
  logic [`AHMP_CNT_W-1:0] cnt;
  logic [`AHMP_CNT_W-1:0] next_cnt;
  logic       wr;
  logic       next_wr;
  ahmp_addr_t addr;
  ahmp_addr_t next_addr;
  ahmp_data_t wdata;
  ahmp_data_t next_wdata;
  logic       next_rsp_valid;
  logic       next_rsp_timeout;
  ahmp_data_t next_rsp_rdata;

  // acknowledge synchroniser
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sync_ack <= 2'h3;
    end else begin
      sync_ack <= {sync_ack[0], port.xfer_ack_n};
    end
  end

  assign cmd_ready_out = (state == AHMP_HST_IDLE);

  // cycle sequencing; strobe held until ack or timeout
  always_comb begin
    next_state       = state;
    next_cnt         = cnt;
    next_wr          = wr;
    next_addr        = addr;
    next_wdata       = wdata;
    next_rsp_valid   = 1'b0;
    next_rsp_timeout = rsp_timeout_out;
    next_rsp_rdata   = rsp_rdata_out;
    unique case (state)
      AHMP_HST_IDLE: begin
        if (cmd_valid_in) begin
          next_wr    = cmd_wr_in;
          next_addr  = cmd_addr_in;
          next_wdata = cmd_wdata_in;
          next_state = AHMP_HST_SETUP;
        end
      end
      AHMP_HST_SETUP: begin
        next_cnt   = '0;
        next_state = AHMP_HST_STROBE;
      end
      AHMP_HST_STROBE: begin
        next_cnt = cnt + `AHMP_CNT_W'(1);
        if (!sync_ack[1]) begin
          next_rsp_rdata   = port.host_data;
          next_rsp_valid   = 1'b1;
          next_rsp_timeout = 1'b0;
          next_state       = AHMP_HST_END;
        end else if (cnt == `AHMP_CNT_W'(`AHMP_TMO_CYC)) begin
          next_rsp_valid   = 1'b1;
          next_rsp_timeout = 1'b1;
          next_state       = AHMP_HST_END;
        end
      end
      AHMP_HST_END: begin
        // wait for the device to let go of ack
        if (sync_ack[1]) begin
          next_state = AHMP_HST_IDLE;
        end
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state           <= AHMP_HST_IDLE;
      cnt             <= '0;
      wr              <= 1'b0;
      addr            <= '0;
      wdata           <= '0;
      rsp_valid_out   <= 1'b0;
      rsp_timeout_out <= 1'b0;
      rsp_rdata_out   <= '0;
    end else begin
      state           <= next_state;
      cnt             <= next_cnt;
      wr              <= next_wr;
      addr            <= next_addr;
      wdata           <= next_wdata;
      rsp_valid_out   <= next_rsp_valid;
      rsp_timeout_out <= next_rsp_timeout;
      rsp_rdata_out   <= next_rsp_rdata;
    end
  end

  // pin drivers; address and direction stable through the cycle
  assign port.sel_n = !(state == AHMP_HST_SETUP ||
                        state == AHMP_HST_STROBE);
  assign port.strobe_n = (state != AHMP_HST_STROBE);
  assign port.rd_wr = !wr;
  assign port.host_addr = addr;
  assign port.host_data_h = wdata;
  assign port.host_data_oe_h = wr && (state != AHMP_HST_IDLE);

endmodule : ahmp_host
`default_nettype wire

//--- core/ahmp_if.sv
// pin bundle between host and device ends of the microport
// assumes both ends share one clock; resolves the shared wires
`timescale 1ns/10ps
`default_nettype none
`include "ahmp_defs.svh"

interface ahmp_if;
  import ahmp_pkg::*;

  logic       sel_n;      // port select, host driven
  logic       strobe_n;   // data strobe, host driven
  logic       rd_wr;      // 1 read, 0 write
  ahmp_addr_t host_addr;
  ahmp_data_t host_data_h; // host data out
  logic       host_data_oe_h;
  ahmp_data_t host_data_d; // device data out
  logic       host_data_oe_d;
  ahmp_data_t host_data;  // resolved bus level
  logic       xfer_ack_n_d; // device pulls ack low
  logic       xfer_ack_oe_d;
  logic       xfer_ack_n; // resolved, pull-up when released

  // wire resolution, pull-up on ack
  assign host_data = host_data_oe_d ? host_data_d :
                     host_data_oe_h ? host_data_h : '1;
  assign xfer_ack_n = xfer_ack_oe_d ? xfer_ack_n_d : 1'b1;

  modport host (
    output sel_n, strobe_n, rd_wr, host_addr, host_data_h,
    output host_data_oe_h,
    input  host_data, xfer_ack_n
  );

  modport device (
    input  sel_n, strobe_n, rd_wr, host_addr, host_data,
    output host_data_d, host_data_oe_d, xfer_ack_n_d, xfer_ack_oe_d
  );

endinterface : ahmp_if
`default_nettype wire

//--- core/ahmp_pkg.sv
// types shared by both ends of the host microport
// assumes ahmp_defs.svh is on the include path
`include "ahmp_defs.svh"

package ahmp_pkg;

  typedef logic [`AHMP_ADDR_W-1:0] ahmp_addr_t;
  typedef logic [`AHMP_DATA_W-1:0] ahmp_data_t;

  // device access sequencer states
  typedef enum logic [1:0] {
    AHMP_DEV_IDLE = 2'b00,
    AHMP_DEV_WAIT = 2'b01,
    AHMP_DEV_ACK  = 2'b10
  } ahmp_dev_st_t;

  // host cycle states
  typedef enum logic [1:0] {
    AHMP_HST_IDLE = 2'b00,
    AHMP_HST_SETUP = 2'b01,
    AHMP_HST_STROBE = 2'b10,
    AHMP_HST_END = 2'b11
  } ahmp_hst_st_t;

endpackage : ahmp_pkg

//--- tb/ahmp_props.sv
// assertions on the microport pins between host and device ends
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none

module ahmp_props
  import ahmp_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic       sel_n,
  input wire logic       strobe_n,
  input wire logic       rd_wr,
  input wire ahmp_addr_t host_addr,
  input wire logic       host_data_oe_h,
  input wire logic       host_data_oe_d,
  input wire logic       xfer_ack_n
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // ----------------------------------------
  // pin relations
  // ----------------------------------------
  a_ack_when_sel: assert property (
    $fell(xfer_ack_n) |-> !sel_n && !strobe_n)
    else $error("ack without select and strobe");
  a_ack_in_time: assert property (
    $fell(strobe_n) |-> ##[1:12] !xfer_ack_n)
    else $error("no ack after strobe");
  a_read_drive: assert property (
    $rose(host_data_oe_d) |-> rd_wr && !sel_n)
    else $error("device drives bus outside read");
  a_write_drive: assert property (
    $rose(host_data_oe_h) |-> !rd_wr)
    else $error("host drives bus on read");
  a_one_driver: assert property (
    !(host_data_oe_d && host_data_oe_h))
    else $error("both ends drive the bus");
  a_addr_steady: assert property (
    !strobe_n && !$past(strobe_n) |-> $stable(host_addr))
    else $error("address moved under strobe");
  a_ack_release: assert property (
    $rose(strobe_n) |-> ##[1:6] xfer_ack_n && !host_data_oe_d)
    else $error("ack or bus not released");
  a_end_after_ack: assert property (
    $rose(strobe_n) |-> !$past(xfer_ack_n))
    else $error("strobe ended before ack");

  // main scenarios
  c_read: cover property ($fell(xfer_ack_n) && rd_wr);
  c_write: cover property ($fell(xfer_ack_n) && !rd_wr);
  c_b2b: cover property ($rose(strobe_n) ##[1:12] $fell(strobe_n));
endmodule : ahmp_props
`default_nettype wire

//--- tb/async_host_microport_test.sv
// testbench joining host and device ends of the microport
// assumes a memory on the device user side answers in the request cycle
`timescale 1ns/10ps
`default_nettype none

module async_host_microport_test
  import ahmp_pkg::*;
;
  logic       ref_clk_in   = 1'b0;
  logic       rst_in       = 1'b1;
  logic       cmd_valid_in = 1'b0;
  logic       cmd_wr_in    = 1'b0;
  ahmp_addr_t cmd_addr_in  = '0;
  ahmp_data_t cmd_wdata_in = '0;
  logic       cmd_ready_out, rsp_valid_out, rsp_timeout_out;
  logic       acc_req_out, acc_wr_out, last_wr;
  ahmp_data_t rsp_rdata_out, acc_wdata_out, acc_rdata_in, last_wdata;
  ahmp_data_t bus_seen;
  ahmp_addr_t acc_addr_out, last_addr;
  ahmp_data_t mem [0:16383];
  int         n_fail = 0, n_compared = 0, n_acc = 0;
  ahmp_addr_t addrs [3] = '{14'h0000, 14'h3fff, 14'h1555};
  ahmp_data_t datas [3] = '{16'h0001, 16'h8000, 16'ha5c3};

  always #25 ref_clk_in = ~ref_clk_in;

  ahmp_if ahmp_if_i ();
  ahmp_dev ahmp_dev_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .port(ahmp_if_i.device), .acc_req_out(acc_req_out),
    .acc_wr_out(acc_wr_out), .acc_addr_out(acc_addr_out),
    .acc_wdata_out(acc_wdata_out), .acc_rdata_in(acc_rdata_in));
  ahmp_host ahmp_host_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .port(ahmp_if_i.host), .cmd_valid_in(cmd_valid_in),
    .cmd_ready_out(cmd_ready_out), .cmd_wr_in(cmd_wr_in),
    .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in),
    .rsp_valid_out(rsp_valid_out), .rsp_timeout_out(rsp_timeout_out),
    .rsp_rdata_out(rsp_rdata_out));
  ahmp_props ahmp_props_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .sel_n(ahmp_if_i.sel_n), .strobe_n(ahmp_if_i.strobe_n),
    .rd_wr(ahmp_if_i.rd_wr), .host_addr(ahmp_if_i.host_addr),
    .host_data_oe_h(ahmp_if_i.host_data_oe_h),
    .host_data_oe_d(ahmp_if_i.host_data_oe_d),
    .xfer_ack_n(ahmp_if_i.xfer_ack_n));

  // ----------------------------------------
  // device user side memory and bus monitor
  // ----------------------------------------
  assign acc_rdata_in = mem[acc_addr_out];
  always @(posedge ref_clk_in) begin
    if (acc_req_out === 1'b1) begin
      n_acc <= n_acc + 1;
      last_wr <= acc_wr_out;
      last_addr <= acc_addr_out;
      last_wdata <= acc_wdata_out;
      if (acc_wr_out === 1'b1) mem[acc_addr_out] <= acc_wdata_out;
    end
  end
  always @(negedge ref_clk_in) begin
    if (ahmp_if_i.xfer_ack_n === 1'b0) bus_seen <= ahmp_if_i.host_data;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input ahmp_data_t seen, input ahmp_data_t exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task access(input logic wr, input ahmp_addr_t a, input ahmp_data_t d,
              output ahmp_data_t rd, output logic to);
    int k;
    k = 0;
    @(negedge ref_clk_in);
    while (cmd_ready_out !== 1'b1 && k < 100) begin
      @(negedge ref_clk_in);
      k++;
    end
    @(posedge ref_clk_in);
    cmd_valid_in <= 1'b1;
    cmd_wr_in <= wr;
    cmd_addr_in <= a;
    cmd_wdata_in <= d;
    @(posedge ref_clk_in);
    cmd_valid_in <= 1'b0;
    k = 0;
    while (rsp_valid_out !== 1'b1 && k < 200) begin
      @(negedge ref_clk_in);
      k++;
    end
    if (k >= 200) n_fail++;
    rd = rsp_rdata_out;
    to = rsp_timeout_out;
  endtask : access

  task results();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_idle();
    check(16'(ahmp_if_i.xfer_ack_n), 16'h0001);
    check(ahmp_if_i.host_data, 16'hffff);
    $display("t_idle done");
  endtask : t_idle

  task t_write_read();
    ahmp_data_t rd;
    logic       to;
    for (int i = 0; i < 3; i++) begin
      access(1'b1, addrs[i], datas[i], rd, to);
      check(16'(last_addr), 16'(addrs[i]));
      check(16'(last_wr), 16'h0001);
      check(last_wdata, datas[i]);
      check(bus_seen, datas[i]);
      check(16'(to), 16'h0000);
    end
    for (int i = 0; i < 3; i++) begin
      access(1'b0, addrs[i], 16'h0000, rd, to);
      check(rd, datas[i]);
      check(16'(last_wr), 16'h0000);
      check(bus_seen, datas[i]);
      check(16'(to), 16'h0000);
    end
    $display("t_write_read done");
  endtask : t_write_read

  task t_back_to_back();
    ahmp_data_t rd;
    logic       to;
    int         n0;
    n0 = n_acc;
    for (int i = 3; i >= 0; i--) begin
      access(1'b0, addrs[i % 3], 16'h0000, rd, to);
      check(rd, datas[i % 3]);
    end
    repeat (4) @(negedge ref_clk_in);
    check(16'(n_acc - n0), 16'h0004);
    check(16'(ahmp_if_i.host_data_oe_d), 16'h0000);
    $display("t_back_to_back done");
  endtask : t_back_to_back

  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    t_idle();
    t_write_read();
    t_back_to_back();
    results();
  end

  // watchdog, far beyond the ten accesses
  initial begin
    #1000000;
    n_fail++;
    results();
  end
endmodule : async_host_microport_test
`default_nettype wire
